// >>> include/aux_option_regs.vh
// register offsets, field positions, reset values and option encodings
`ifndef AUX_OPTION_REGS_VH
`define AUX_OPTION_REGS_VH
`define AUXC_ADDR 8'h8e
`define AUXC_RESET 8'h00
`define AUXC_T0_FAST_BIT 7
`define AUXC_T1_FAST_BIT 6
`define AUXC_URM0_BIT 5
`define AUXC_ADC_IE_BIT 4
`define AUXC_SPI_IE_BIT 3
`define AUXC_LV_IE_BIT 2
`define AUXC_WR_MASK 8'hfc
`define DIV12_LAST 4'hb
`define DIV2_LAST 4'h1
`define ISP_NONE 2'h0
`define ISP_1K 2'h1
`define ISP_2K 2'h2
`define ISP_3K 2'h3
`define ISP_START_1K 13'h1c00
`define ISP_START_2K 13'h1800
`define ISP_START_3K 13'h1400
`define FLASH_END 13'h1fff
`define AP_START 13'h0000
`define DUMP_LOCKED 8'hff
`define IAP_SIZE_DEFAULT 2'h1
`define WDT_FIELD_RESET 4'h0
`endif

// >>> core/rate_divider.v
// divides the system clock into a one-cycle tick at a selectable rate
`timescale 1ns/1ps
module rate_divider (
	input wire clk_sys,
	input wire sys_rst,
	input wire fast_sel,
	input wire [3:0] slow_last,
	input wire [3:0] fast_last,
	output reg tick
);
	reg [3:0] count_q;
	wire [3:0] last = fast_sel ? fast_last : slow_last;
	// free-running count, tick on wrap
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			count_q <= 4'h0;
			tick <= 1'b0;
		end else if (count_q >= last) begin
			count_q <= 4'h0;
			tick <= 1'b1;
		end else begin
			count_q <= count_q + 4'h1;
			tick <= 1'b0;
		end
	end
endmodule

// >>> core/fuse_latch.v
// holds the option fuse word captured once at power-on
`timescale 1ns/1ps
module fuse_latch (
	input wire clk_sys,
	input wire sys_rst,
	input wire [15:0] fuse_in,
	output reg [15:0] fuse_q,
	output reg loaded
);
	// sample after reset release, then hold until the next power-on
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			fuse_q <= 16'h0000;
			loaded <= 1'b0;
		end else if (!loaded) begin
			fuse_q <= fuse_in;
			loaded <= 1'b1;
		end
	end
endmodule

// >>> core/aux_control_and_option_fuses.v
// auxiliary control register and power-on option fuse logic
// Operation
// - timer 0 in timer mode: bit 7 clear gives clock/12, set gives clock
// - timer 1 in timer mode: bit 6 clear gives clock/12, set gives clock
// - serial mode 0 rate: bit 5 clear gives clock/12, set gives clock/2
// - bit 4 gates the converter interrupt request
// - bit 3 gates the serial peripheral interrupt request
// - bit 2 gates the low-voltage flag interrupt
// - erased fuses leave every option disabled and no programming areas
// - readout lock returns 0xff for every dumped byte
// - scramble option returns dumped code scrambled, else unaltered
// - programming area starts at 0x1400, 0x1800 or 0x1c00, ends 0x1fff
// - shipped default programming area size is 1K
// - boot select with area configured boots from area, else application
// - application programming area size set by fuse, default 1K
// - low-voltage reset option lets detection reset to application start
// - write protect option blocks flash writes while low-voltage flag set
// - oscillator option picks internal 6MHz oscillator or crystal at power-on
// - watchdog auto-enable sets enable and loads four fused bits at power-on
// - watchdog write protect ignores writes to idle count and prescalers
`timescale 1ns/1ps
`include "aux_option_regs.vh"
module aux_control_and_option_fuses (
	input wire clk_sys,
	input wire sys_rst,
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata,
	output wire sfr_hit,
	input wire timer0_counter_mode,
	input wire timer1_counter_mode,
	input wire timer0_pin_tick,
	input wire timer1_pin_tick,
	output wire timer0_tick,
	output wire timer1_tick,
	output wire serial_mode0_tick,
	input wire converter_irq_req,
	input wire serial_periph_irq_req,
	input wire low_voltage_flag,
	output wire converter_irq,
	output wire serial_periph_irq,
	output wire low_voltage_irq,
	input wire [15:0] fuse_word,
	input wire [2:0] fuse_iap_size,
	output reg [12:0] isp_start,
	output wire isp_present,
	output reg [12:0] boot_address,
	output wire [2:0] iap_size,
	input wire low_voltage_detector,
	output wire low_voltage_reset_req,
	input wire flash_write_req,
	output wire flash_write_ok,
	output wire internal_osc_sel,
	output wire crystal_low_gain,
	input wire dump_rd,
	input wire [7:0] dump_code,
	input wire [12:0] dump_addr,
	output reg [7:0] dump_data,
	input wire wdt_wr,
	input wire [3:0] wdt_wdata,
	output reg watchdog_enable_bit,
	output reg [3:0] watchdog_ctrl_fields,
	output wire options_valid
);
	// fuse word layout: each single-bit option reads 1 when enabled; the isp code and watchdog fields are multi-bit values
	localparam FB_LOCK = 0;
	localparam FB_SCRAMBLE = 1;
	localparam FB_ISP_LO = 2;
	localparam FB_BOOT_ISP = 4;
	localparam FB_LVR = 5;
	localparam FB_LVWP = 6;
	localparam FB_LOWGAIN = 7;
	localparam FB_INT_OSC = 8;
	localparam FB_WDT_AUTO = 9;
	localparam FB_WDT_FIELDS = 10;
	localparam FB_WDT_WP = 14;

	// power-on sequence states
	localparam ST_LOAD = 3'b001;
	localparam ST_APPLY = 3'b010;
	localparam ST_RUN = 3'b100;

	wire [15:0] fuse_q;
	wire fuse_loaded;
	reg [7:0] auxc_q;
	reg [2:0] state_q;
	reg [2:0] iap_q;

	// option fuses captured once after power-on
	fuse_latch u_fuse (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.fuse_in(fuse_word),
		.fuse_q(fuse_q),
		.loaded(fuse_loaded)
	);

	wire opt_lock = fuse_q[FB_LOCK];
	wire opt_scramble = fuse_q[FB_SCRAMBLE];
	wire [1:0] opt_isp = fuse_q[FB_ISP_LO+1:FB_ISP_LO];
	wire opt_boot_isp = fuse_q[FB_BOOT_ISP];
	wire opt_lvr = fuse_q[FB_LVR];
	wire opt_lvwp = fuse_q[FB_LVWP];
	wire opt_wdt_auto = fuse_q[FB_WDT_AUTO];
	wire opt_wdt_wp = fuse_q[FB_WDT_WP];

	// start address of the programming area for a size code
	function [12:0] isp_base;
		input [1:0] code;
		begin
			if (code == `ISP_3K)
				isp_base = `ISP_START_3K;
			else if (code == `ISP_2K)
				isp_base = `ISP_START_2K;
			else if (code == `ISP_1K)
				isp_base = `ISP_START_1K;
			else
				isp_base = `FLASH_END;
		end
	endfunction

	// simple reversible byte scramble keyed by address
	function [7:0] scramble;
		input [7:0] d;
		input [12:0] a;
		begin
			scramble = {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]} ^ a[7:0];
		end
	endfunction

	// sequence: load fuses, apply power-on effects, then run
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_LOAD;
		end else begin
			case (state_q)
				ST_LOAD: begin
					if (fuse_loaded)
						state_q <= ST_APPLY;
				end
				ST_APPLY: begin
					state_q <= ST_RUN;
				end
				ST_RUN: begin
					state_q <= ST_RUN;
				end
				default: begin
					state_q <= ST_LOAD;
				end
			endcase
		end
	end
	assign options_valid = (state_q == ST_RUN);

	// auxiliary control register, low two bits ignore writes and are kept zero
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			auxc_q <= `AUXC_RESET;
		else if (sfr_wr && sfr_addr == `AUXC_ADDR)
			auxc_q <= sfr_wdata & `AUXC_WR_MASK;
	end

	// register read, low bits read back as zero
	assign sfr_hit = (sfr_addr == `AUXC_ADDR);
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			sfr_rdata <= 8'h00;
		else if (sfr_rd && sfr_hit)
			sfr_rdata <= auxc_q;
		else if (sfr_rd)
			sfr_rdata <= 8'h00;
	end

	// timer clock prescale per timer
	wire t0_pre;
	wire t1_pre;
	rate_divider u_t0 (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.fast_sel(auxc_q[`AUXC_T0_FAST_BIT]),
		.slow_last(`DIV12_LAST),
		.fast_last(4'h0),
		.tick(t0_pre)
	);
	rate_divider u_t1 (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.fast_sel(auxc_q[`AUXC_T1_FAST_BIT]),
		.slow_last(`DIV12_LAST),
		.fast_last(4'h0),
		.tick(t1_pre)
	);
	// counter mode bypasses the prescale and counts pin events
	assign timer0_tick = timer0_counter_mode ? timer0_pin_tick : t0_pre;
	assign timer1_tick = timer1_counter_mode ? timer1_pin_tick : t1_pre;

	// serial mode 0 shift rate
	rate_divider u_sm0 (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.fast_sel(auxc_q[`AUXC_URM0_BIT]),
		.slow_last(`DIV12_LAST),
		.fast_last(`DIV2_LAST),
		.tick(serial_mode0_tick)
	);

	// interrupt gating
	assign converter_irq = converter_irq_req & auxc_q[`AUXC_ADC_IE_BIT];
	assign serial_periph_irq = serial_periph_irq_req & auxc_q[`AUXC_SPI_IE_BIT];
	assign low_voltage_irq = low_voltage_flag & auxc_q[`AUXC_LV_IE_BIT];

	// memory map: zero fuses mean no area configured
	assign isp_present = (opt_isp != `ISP_NONE);
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			isp_start <= `FLASH_END;
			boot_address <= `AP_START;
			iap_q <= 3'h0;
		end else if (state_q == ST_APPLY) begin
			isp_start <= isp_base(opt_isp);
			iap_q <= fuse_iap_size;
			if (opt_boot_isp && isp_present)
				boot_address <= isp_base(opt_isp);
			else
				boot_address <= `AP_START;
		end
	end
	assign iap_size = iap_q;

	// low-voltage reset and flash write inhibit
	assign low_voltage_reset_req = opt_lvr & low_voltage_detector & options_valid;
	assign flash_write_ok = flash_write_req & ~(opt_lvwp & low_voltage_flag);

	// oscillator choice, held static after power-on
	assign internal_osc_sel = fuse_q[FB_INT_OSC];
	assign crystal_low_gain = fuse_q[FB_LOWGAIN];

	// external programmer dump path
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			dump_data <= 8'h00;
		else if (dump_rd) begin
			if (opt_lock)
				dump_data <= `DUMP_LOCKED;
			else if (opt_scramble)
				dump_data <= scramble(dump_code, dump_addr);
			else
				dump_data <= dump_code;
		end
	end

	// watchdog enable and fields: power-on load, protected software writes
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			watchdog_enable_bit <= 1'b0;
			watchdog_ctrl_fields <= `WDT_FIELD_RESET;
		end else if (state_q == ST_APPLY) begin
			if (opt_wdt_auto) begin
				watchdog_enable_bit <= 1'b1;
				watchdog_ctrl_fields <= fuse_q[FB_WDT_FIELDS+3:FB_WDT_FIELDS];
			end
		end else if (wdt_wr && options_valid && !opt_wdt_wp) begin
			watchdog_ctrl_fields <= wdt_wdata;
		end
	end
endmodule

// >>> sim/aux_control_and_option_fuses_asserts.sv
// port checker for the auxiliary control and option fuse block
`timescale 1ns/1ps
module aux_fuse_checker (
	input wire clk_sys,
	input wire sys_rst,
	input wire sfr_rd,
	input wire sfr_hit,
	input wire [7:0] sfr_rdata,
	input wire timer0_counter_mode,
	input wire timer0_pin_tick,
	input wire timer0_tick,
	input wire serial_mode0_tick,
	input wire converter_irq_req,
	input wire converter_irq,
	input wire low_voltage_flag,
	input wire low_voltage_irq,
	input wire [15:0] fuse_word,
	input wire [12:0] isp_start,
	input wire isp_present,
	input wire [12:0] boot_address,
	input wire flash_write_req,
	input wire flash_write_ok,
	input wire dump_rd,
	input wire [7:0] dump_data,
	input wire options_valid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// one tick followed by a quiet cycle
	sequence tick_gap_s;
		serial_mode0_tick ##1 !serial_mode0_tick;
	endsequence
	rate_gap_a: assert property (serial_mode0_tick |-> tick_gap_s)
		else $error("serial tick repeated at once");
	rate_max_a: assert property (tick_gap_s |-> ##[1:11] serial_mode0_tick)
		else $error("serial tick too slow");
	conv_gate_a: assert property (converter_irq |-> converter_irq_req)
		else $error("converter irq without request");
	lv_gate_a: assert property (low_voltage_irq |-> low_voltage_flag)
		else $error("low voltage irq without flag");
	write_block_a: assert property (flash_write_ok |-> flash_write_req)
		else $error("flash write ok without request");
	count_mode_a: assert property (timer0_counter_mode |-> timer0_tick == timer0_pin_tick)
		else $error("timer0 tick not from pin in counter mode");
	lock_dump_a: assert property (dump_rd && options_valid && fuse_word[0]
		|=> dump_data == 8'hff)
		else $error("locked dump not 0xff");
	isp_none_a: assert property (options_valid && !isp_present
		|-> isp_start == 13'h1fff && boot_address == 13'h0000)
		else $error("no isp area but start or boot wrong");
	resv_read_a: assert property (sfr_rd && sfr_hit |=> sfr_rdata[1:0] == 2'b00)
		else $error("reserved bits read nonzero");
	held_cfg_a: assert property (options_valid |=> options_valid && $stable(isp_start))
		else $error("latched options changed");
endmodule
bind aux_control_and_option_fuses aux_fuse_checker u_chk (.*);

// >>> sim/aux_control_and_option_fuses_tb.sv
// self-checking bench for the auxiliary control and option fuse block
`timescale 1ns/1ps
module aux_control_and_option_fuses_tb;
	logic clk_sys = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, dump_rd = 0, wdt_wr = 0;
	logic timer0_counter_mode = 0, timer1_counter_mode = 0, timer0_pin_tick = 1;
	logic timer1_pin_tick = 0, converter_irq_req = 1, serial_periph_irq_req = 1;
	logic low_voltage_flag = 1, low_voltage_detector = 1, flash_write_req = 1;
	logic [7:0] sfr_addr = 8'h8e, sfr_wdata = 8'h00, dump_code = 8'h35, sfr_rdata, dump_data;
	logic [15:0] fuse_word = 16'h0000;
	logic [2:0] fuse_iap_size = 3'h1, iap_size;
	logic [12:0] dump_addr = 13'h0a6, isp_start, boot_address;
	logic [3:0] wdt_wdata = 4'h0, watchdog_ctrl_fields;
	logic sfr_hit, timer0_tick, timer1_tick, serial_mode0_tick, converter_irq;
	logic serial_periph_irq, low_voltage_irq, isp_present, low_voltage_reset_req;
	logic flash_write_ok, internal_osc_sel, crystal_low_gain, watchdog_enable_bit, options_valid;
	int n_fail = 0, num_checks = 0;
	logic [15:0] cfg [4] = '{16'h0000, 16'h4f35, 16'h14ca, 16'h321f};
	aux_control_and_option_fuses DUT (.*);
	// 20 MHz system clock
	always #25 clk_sys = ~clk_sys;
	task automatic chk(string nm, logic [15:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// one register cycle, strobe held for one clock
	task automatic sfr(logic w, logic [7:0] a, d);
		@(negedge clk_sys);
		sfr_wr = w;
		sfr_rd = !w;
		sfr_addr = a;
		sfr_wdata = d;
		@(negedge clk_sys);
		sfr_wr = 0;
		sfr_rd = 0;
	endtask
	// set the rate bits, let them settle, count ticks over 24 clocks
	task automatic count(logic [7:0] v, int e0, e1, es);
		int c0, c1, cs;
		c0 = 0;
		c1 = 0;
		cs = 0;
		sfr(1, 8'h8e, v);
		repeat (12) @(negedge clk_sys);
		repeat (24) begin
			@(posedge clk_sys);
			#1;
			c0 += timer0_tick;
			c1 += timer1_tick;
			cs += serial_mode0_tick;
		end
		chk("tick0", e0, c0);
		chk("tick1", e1, c1);
		chk("tick_ser", es, cs);
	endtask
	// power-on with fuse word f, then check every derived option
	task automatic apply(logic [15:0] f);
		logic [12:0] st;
		logic [3:0] fl;
		int k;
		st = f[3:2] == 1 ? 13'h1c00 : f[3:2] == 2 ? 13'h1800 : f[3:2] == 3 ? 13'h1400 : 13'h1fff;
		fl = f[9] ? f[13:10] : 4'h0;
		k = 0;
		@(negedge clk_sys);
		sys_rst = 1;
		fuse_word = f;
		fuse_iap_size = f[2:0];
		repeat (16) @(negedge clk_sys);
		sys_rst = 0;
		while (options_valid !== 1'b1) begin
			@(negedge clk_sys);
			if (++k > 10) begin
				n_fail++;
				end_of_test();
			end
		end
		chk("isp_start", st, isp_start);
		chk("isp_present", f[3:2] != 0, isp_present);
		chk("boot", (f[4] && f[3:2] != 0) ? st : 13'h0, boot_address);
		chk("osc", f[8], internal_osc_sel);
		chk("gain", f[7], crystal_low_gain);
		chk("iap", f[2:0], iap_size);
		chk("lv_reset", f[5], low_voltage_reset_req);
		chk("wr_ok", !f[6], flash_write_ok);
		chk("wdt_en", f[9], watchdog_enable_bit);
		chk("wdt_fld", fl, watchdog_ctrl_fields);
		@(negedge clk_sys);
		wdt_wr = 1;
		wdt_wdata = 4'h9;
		dump_rd = 1;
		@(negedge clk_sys);
		wdt_wr = 0;
		dump_rd = 0;
		chk("wdt_wp", f[14] ? fl : 4'h9, watchdog_ctrl_fields);
		chk("dump", f[0] ? 8'hff : f[1] ? 8'h0a : 8'h35, dump_data);
	endtask
	initial begin
		logic [2:0] irq_v;
		foreach (cfg[i]) apply(cfg[i]);
		sfr(0, 8'h8e, 8'h00);
		chk("auxc_rst", 8'h00, sfr_rdata);
		sfr(1, 8'h8e, 8'hfc);
		sfr(0, 8'h8e, 8'h00);
		chk("auxc", 8'hfc, sfr_rdata);
		chk("hit_aux", 16'h0001, sfr_hit);
		sfr(0, 8'h8f, 8'h00);
		chk("other", 8'h00, sfr_rdata);
		chk("hit_other", 16'h0000, sfr_hit);
		// each enable bit alone, then none
		for (int b = 2; b < 6; b++) begin
			sfr(1, 8'h8e, 8'h01 << b);
			irq_v = {converter_irq, serial_periph_irq, low_voltage_irq};
			chk("irq", b < 5 ? 3'b001 << (b - 2) : 3'b000, irq_v);
		end
		count(8'h00, 2, 2, 2);
		count(8'h80, 24, 2, 2);
		count(8'h40, 2, 24, 2);
		count(8'h20, 2, 2, 12);
		// both timers counting pin events: pin 0 held high, pin 1 held low
		@(negedge clk_sys);
		timer0_counter_mode = 1;
		timer1_counter_mode = 1;
		count(8'h00, 24, 0, 2);
		end_of_test();
	end
endmodule
